/* core/card_clk_gen.sv */
// card clock divider: makes the card clock from the system clock
// assumes run is a clean level; clock parks low while run is low
`timescale 1ns/1ps
`default_nettype none
`include "card_session_map.svh"
module card_clk_gen
  import card_session_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic run,
  // card clock and one pulse per card cycle
  output logic card_clk,
  output logic tick
);

  localparam logic [5:0] HALF = 6'(`CLK_HALF_CYC);

  clkgen_reg_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.tick = 1'b0;
    if (!run) begin
      r_d.div = '0;
      r_d.card_clk = 1'b0;
    end else if (r_q.div == HALF - 6'h01) begin
      r_d.div = '0;
      r_d.card_clk = !r_q.card_clk;
      // count a card cycle at each rising edge
      r_d.tick = !r_q.card_clk;
    end else begin
      r_d.div = r_q.div + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign card_clk = r_q.card_clk;
  assign tick = r_q.tick;

endmodule // card_clk_gen
`default_nettype wire

/* core/card_session_map.svh */
// offsets-free constant map: timing counts and reset values of the card session sequencer
// assumes a 250 MHz system clock; card clock counts are in card clock cycles
`ifndef CARD_SESSION_MAP_SVH
`define CARD_SESSION_MAP_SVH

// system clock and card clock rates
`define SYS_CLK_KHZ 250000
`define SYS_PERIOD_NS 4
`define CARD_CLK_KHZ 4000
`define CLK_HALF_CYC (((`SYS_CLK_KHZ) + 2 * (`CARD_CLK_KHZ) - 1) / (2 * (`CARD_CLK_KHZ)))

// reset hold and answer window, card clock cycles
`define RST_HOLD_DEF 16'd42000
`define ATR_MIN_CYC 16'd400
`define ATR_MAX_DEF 16'd40000

// bit period in card clock cycles (rate integer over multiplier)
`define RATE_F 9'd372
`define RATE_D 9'd1
`define ETU_CYC (`RATE_F / `RATE_D)

// deactivation step dwell and withdrawal budget, ns
`define DEACT_STEP_NS 1000
`define DEACT_STEP_CYC ((`DEACT_STEP_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define WITHDRAW_BUDGET_NS 1000000

// input synchroniser indices
`define SYN_SEAT 0
`define SYN_PULL 1
`define SYN_VOK 2
`define SYN_IO 3
`define SYN_N 4

`endif

/* core/card_session_pkg.sv */
// types of the card session sequencer
// assumes card_session_map.svh supplies the numeric constants
package card_session_pkg;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_POWER = 10'b00_0000_0010,
    ST_COLD = 10'b00_0000_0100,
    ST_ATR = 10'b00_0000_1000,
    ST_SESSION = 10'b00_0001_0000,
    ST_WARM = 10'b00_0010_0000,
    ST_DRST = 10'b00_0100_0000,
    ST_DCLK = 10'b00_1000_0000,
    ST_DPWR = 10'b01_0000_0000,
    ST_DONE = 10'b10_0000_0000
  } seq_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_reg_t;

  typedef struct packed {
    logic [5:0] div;
    logic card_clk;
    logic tick;
  } clkgen_reg_t;

  typedef struct packed {
    seq_state_t st;
    logic [15:0] cnt;
    logic [8:0] etu_cnt;
    logic [7:0] step;
    logic warm_done;
    logic io_prev;
    logic supply_en;
    logic card_rst;
    logic clk_run;
    logic io_out;
    logic io_oe_n;
    logic atr_start;
    logic atr_timeout;
    logic etu_tick;
    logic ready;
  } seq_reg_t;

endpackage

/* core/card_session_sequencer.sv */
// card session sequencer: activation, cold and warm reset, answer supervision, deactivation
// assumes the contact pins are driven by pad cells; io is split into in, out and active-low enable
`timescale 1ns/1ps
`default_nettype none
`include "card_session_map.svh"
module card_session_sequencer
  import card_session_pkg::*;
#(
  parameter logic [15:0] RST_HOLD_CYC = `RST_HOLD_DEF,
  parameter logic [15:0] ATR_MAX_CYC = `ATR_MAX_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // coupler sensing (asynchronous pins)
  input wire logic card_seated,
  input wire logic card_pulled,
  input wire logic supply_ok,
  // terminal control (same clock)
  input wire logic start_req,
  input wire logic end_req,
  input wire logic atr_bad,
  input wire logic tx_active,
  input wire logic tx_level,
  // card contacts
  output logic supply_en,
  output logic card_rst,
  output logic card_clk,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe_n,
  // status
  output logic session_ready,
  output logic atr_start,
  output logic atr_timeout,
  output logic etu_tick,
  output logic io_rx,
  output logic idle
);

  localparam logic [8:0] ETU = 9'(`ETU_CYC);
  localparam logic [7:0] STEP = 8'(`DEACT_STEP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [`SYN_N-1:0] pins;
  logic [`SYN_N-1:0] syn;

  assign pins = {io_in, supply_ok, card_pulled, card_seated};

  genvar gi;
  generate
    for (gi = 0; gi < `SYN_N; gi++) begin : g_sync
      pin_sync u_sync (
        .clock(clock),
        .srst(srst),
        .pin(pins[gi]),
        .level(syn[gi])
      );
    end
  endgenerate

  logic seated;
  logic pulled;
  logic vok;
  logic io_lvl;

  assign seated = syn[`SYN_SEAT];
  assign pulled = syn[`SYN_PULL];
  assign vok = syn[`SYN_VOK];
  assign io_lvl = syn[`SYN_IO];

  ////////////////////////////////////////////////////////////////////////////
  // card clock

  seq_reg_t r_q, r_d;
  logic tick;

  card_clk_gen u_clk (
    .clock(clock),
    .srst(srst),
    .run(r_q.clk_run),
    .card_clk(card_clk),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  logic in_session;
  logic io_fall;
  logic quit;

  assign in_session = r_q.st inside {ST_POWER, ST_COLD, ST_ATR, ST_SESSION, ST_WARM};
  // io start bit edge, after the synchroniser
  assign io_fall = r_q.io_prev && !io_lvl;
  // withdrawal, seat loss or an end request beats every other cause
  assign quit = pulled || !seated || end_req;

  always_comb begin
    r_d = r_q;
    r_d.io_prev = io_lvl;
    r_d.atr_start = 1'b0;
    r_d.atr_timeout = 1'b0;
    r_d.etu_tick = 1'b0;

    // bit period runs off the card clock while the card is reset-released
    if (r_q.st inside {ST_ATR, ST_SESSION} && tick) begin
      if (r_q.etu_cnt == ETU - 9'h001) begin
        r_d.etu_cnt = '0;
        r_d.etu_tick = 1'b1;
      end else begin
        r_d.etu_cnt = r_q.etu_cnt + 9'h001;
      end
    end

    case (r_q.st)
      ST_IDLE: begin
        // contacts parked low before and between sessions
        r_d.supply_en = 1'b0;
        r_d.card_rst = 1'b0;
        r_d.clk_run = 1'b0;
        r_d.io_out = 1'b0;
        r_d.io_oe_n = 1'b0;
        r_d.warm_done = 1'b0;
        if (start_req && seated && !pulled) begin
          r_d.st = ST_POWER;
          r_d.supply_en = 1'b1;
        end
      end

      ST_POWER: begin
        r_d.card_rst = 1'b0;
        if (quit) begin
          r_d.st = ST_DRST;
          r_d.step = '0;
        end else if (vok) begin
          // clock start instant; io released at once
          r_d.st = ST_COLD;
          r_d.clk_run = 1'b1;
          r_d.io_oe_n = 1'b1;
          r_d.cnt = '0;
        end
      end

      ST_COLD, ST_WARM: begin
        r_d.card_rst = 1'b0;
        r_d.io_oe_n = 1'b1;
        if (quit) begin
          r_d.st = ST_DRST;
          r_d.step = '0;
        end else if (tick) begin
          if (r_q.cnt == RST_HOLD_CYC - 16'h0001) begin
            r_d.st = ST_ATR;
            r_d.card_rst = 1'b1;
            r_d.cnt = '0;
            r_d.etu_cnt = '0;
          end else begin
            r_d.cnt = r_q.cnt + 16'h0001;
          end
        end
      end

      ST_ATR: begin
        r_d.io_oe_n = 1'b1;
        if (quit) begin
          r_d.st = ST_DRST;
          r_d.step = '0;
        end else if (io_fall) begin
          if (r_q.cnt >= `ATR_MIN_CYC) begin
            r_d.st = ST_SESSION;
            r_d.atr_start = 1'b1;
            // bit period aligned to the start bit
            r_d.etu_cnt = '0;
          end else begin
            r_d.st = ST_DRST;
            r_d.step = '0;
          end
        end else if (tick) begin
          if (r_q.cnt == ATR_MAX_CYC) begin
            r_d.st = ST_DRST;
            r_d.step = '0;
            r_d.atr_timeout = 1'b1;
          end else begin
            r_d.cnt = r_q.cnt + 16'h0001;
          end
        end
      end

      ST_SESSION: begin
        // half duplex: drive only while the terminal sends
        r_d.io_oe_n = !tx_active;
        r_d.io_out = tx_level;
        if (quit) begin
          r_d.st = ST_DRST;
          r_d.step = '0;
          r_d.io_oe_n = 1'b1;
        end else if (atr_bad) begin
          if (r_q.warm_done) begin
            r_d.st = ST_DRST;
            r_d.step = '0;
          end else begin
            // warm reset start: supply and clock untouched
            r_d.st = ST_WARM;
            r_d.card_rst = 1'b0;
            r_d.io_oe_n = 1'b1;
            r_d.warm_done = 1'b1;
            r_d.cnt = '0;
          end
        end
      end

      ST_DRST: begin
        r_d.card_rst = 1'b0;
        r_d.io_oe_n = 1'b1;
        if (r_q.step == STEP - 8'h01) begin
          r_d.st = ST_DCLK;
          r_d.step = '0;
          r_d.clk_run = 1'b0;
          r_d.io_out = 1'b0;
          r_d.io_oe_n = 1'b0;
        end else begin
          r_d.step = r_q.step + 8'h01;
        end
      end

      ST_DCLK: begin
        if (r_q.step == STEP - 8'h01) begin
          r_d.st = ST_DPWR;
          r_d.step = '0;
          r_d.supply_en = 1'b0;
        end else begin
          r_d.step = r_q.step + 8'h01;
        end
      end

      ST_DPWR: begin
        // let the supply fall before reporting done
        if (r_q.step == STEP - 8'h01) begin
          r_d.st = ST_DONE;
          r_d.step = '0;
        end else begin
          r_d.step = r_q.step + 8'h01;
        end
      end

      ST_DONE: begin
        // a fresh insertion is needed before the next session
        if (!seated) begin
          r_d.st = ST_IDLE;
        end
      end

      default: begin
        r_d.st = ST_DRST;
        r_d.step = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign supply_en = r_q.supply_en;
  assign card_rst = r_q.card_rst;
  assign io_out = r_q.io_out;
  assign io_oe_n = r_q.io_oe_n;
  assign session_ready = (r_q.st == ST_SESSION);
  assign atr_start = r_q.atr_start;
  assign atr_timeout = r_q.atr_timeout;
  assign etu_tick = r_q.etu_tick;
  assign io_rx = io_lvl;
  assign idle = !in_session && !(r_q.st inside {ST_DRST, ST_DCLK, ST_DPWR});

endmodule // card_session_sequencer
`default_nettype wire

/* core/pin_sync.sv */
// three-stage synchroniser for one pin input
// assumes the pin is asynchronous to clock; level moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import card_session_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // pin side
  input wire logic pin,
  // clocked side
  output logic level
);

  sync_reg_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.s1 = pin;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 == r_q.s3) begin
      r_d.level = r_q.s3;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign level = r_q.level;

endmodule // pin_sync
`default_nettype wire

/* dv/card_session_checker_assertions.sv */
// concurrent checks on the card session sequencer ports
// assumes one clock domain and the 64-cycle card clock of the design
`timescale 1ns/1ps
`default_nettype none
module card_session_checker (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control inputs
  input wire logic atr_bad,
  input wire logic tx_active,
  // contacts and status
  input wire logic supply_en,
  input wire logic card_rst,
  input wire logic card_clk,
  input wire logic io_out,
  input wire logic io_oe_n,
  input wire logic session_ready,
  input wire logic atr_start,
  input wire logic atr_timeout,
  input wire logic etu_tick
);
  localparam logic [15:0] ETU_SYS = 16'd23807;
  logic [15:0] low_q;
  logic [15:0] gap_q;
  logic seen_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // clock-low run length and cycles between bit ticks
  always_ff @(posedge clock) begin
    if (srst) begin
      low_q <= 16'h0;
      gap_q <= 16'h0;
      seen_q <= 1'b0;
    end else begin
      low_q <= card_clk ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
      gap_q <= etu_tick ? 16'h0 : gap_q + 16'h1;
      seen_q <= card_rst && !atr_start && (seen_q || etu_tick);
    end
  end
  ////////////////////////////////////////
  AST_UNPOWERED_LOW: assert property (!supply_en |-> !card_clk && !card_rst && !io_out && !io_oe_n)
    else $error("contact active without supply");
  AST_READY_CAUSE: assert property ($rose(session_ready) |-> atr_start)
    else $error("session ready without answer start");
  AST_TIMEOUT_DEACT: assert property (atr_timeout |-> ##[0:2] (!card_rst [*8]))
    else $error("no reset low after answer timeout");
  AST_SUPPLY_LAST: assert property ($fell(supply_en) |-> !card_rst && !io_out && !io_oe_n && low_q >= 16'd200)
    else $error("supply removed before reset clock and io low");
  AST_WARM_HOLD: assert property (atr_bad && session_ready |=> (!card_rst && supply_en && io_oe_n) [*8])
    else $error("warm reset entry wrong");
  AST_WARM_CLK: assert property (atr_bad && session_ready |-> ##[1:70] $rose(card_clk))
    else $error("card clock stopped in warm reset");
  AST_IO_RX: assert property (session_ready && !tx_active |=> io_oe_n)
    else $error("io driven while not sending");
  AST_ETU: assert property (etu_tick && seen_q |-> gap_q == ETU_SYS)
    else $error("bit period not 372 card clocks");
endmodule // card_session_checker
bind card_session_sequencer card_session_checker chk (.clock, .srst, .atr_bad, .tx_active, .supply_en,
  .card_rst, .card_clk, .io_out, .io_oe_n, .session_ready, .atr_start, .atr_timeout, .etu_tick);
`default_nettype wire

/* dv/chip_card_model.sv */
// behavioural chip card behind the contacts, with the line pull-up
// assumes the bench chooses whether and when the card answers
`timescale 1ns/1ps
`default_nettype none
module chip_card_model (
  // contacts
  input wire logic supply_en,
  input wire logic card_rst,
  input wire logic card_clk,
  input wire logic io_out,
  input wire logic io_oe_n,
  output logic io_line,
  // answer control
  input wire logic ans_en,
  input wire logic [15:0] ans_delay
);
  int cnt = 0;
  logic drive_low = 1'b0;
  // reset is active low; the answer counts card clocks from its release
  always @(posedge card_clk or negedge card_rst) begin
    if (!card_rst) begin
      cnt <= 0;
      drive_low <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (ans_en && cnt == ans_delay) drive_low <= 1'b1;
      if (cnt == ans_delay + 372) drive_low <= 1'b0;
    end
  end
  // shared half-duplex line, pulled up only while powered
  assign io_line = !io_oe_n ? io_out : (supply_en && !drive_low);
endmodule // chip_card_model
`default_nettype wire

/* dv/tb_card_session_sequencer.sv */
// self-checking bench for the card session sequencer
// assumes the card model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_card_session_sequencer;
  import card_session_pkg::*;
  localparam logic [15:0] HOLD = 16'd40;
  localparam logic [15:0] AMAX = 16'd760;
  logic clock, srst, card_seated, card_pulled, supply_ok, start_req, end_req, atr_bad;
  logic tx_active, tx_level, io_in, ans_en, supply_en, card_rst, card_clk, io_out, io_oe_n;
  logic session_ready, atr_start, atr_timeout, etu_tick, io_rx, idle;
  logic [15:0] ans_delay;
  logic [1:0] exp_q[$];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int hold_cnt = 0;
  int t0;
  int seed = 32'hc534ff5d;
  card_session_sequencer #(.RST_HOLD_CYC(HOLD), .ATR_MAX_CYC(AMAX)) dut (.clock, .srst, .card_seated,
    .card_pulled, .supply_ok, .start_req, .end_req, .atr_bad, .tx_active, .tx_level, .supply_en, .card_rst,
    .card_clk, .io_in, .io_out, .io_oe_n, .session_ready, .atr_start, .atr_timeout, .etu_tick, .io_rx, .idle);
  chip_card_model card (.supply_en, .card_rst, .card_clk, .io_out, .io_oe_n, .io_line(io_in), .ans_en,
    .ans_delay);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // start a session and power the card, clock held until supply is good
  task automatic activate;
    hold_cnt = 0;
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    for (int i = 0; i < 8 && !supply_en; i++) @(posedge clock);
    check("supply_on", supply_en, 1'b1);
    repeat (50) @(posedge clock);
    check("clk_before_ok", {card_clk, card_rst}, 2'b00);
    supply_ok <= 1'b1;
    for (int i = 0; i < 3000 && !card_rst; i++) @(posedge clock);
    check("hold", 16'(hold_cnt), HOLD);
    check("io_rx_mode", io_oe_n, 1'b1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 99000) begin
      errors++;
      finish_test();
    end
  end
  always @(posedge card_clk) if (!card_rst && supply_en) hold_cnt++;
  // result watcher
  always @(posedge clock) begin
    if (!srst && (atr_start || atr_timeout)) begin
      if (exp_q.size() == 0) check("result", {atr_start, atr_timeout}, 2'b00);
      else check("result", {atr_start, atr_timeout}, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////
  initial begin
    {srst, card_seated, card_pulled, supply_ok, start_req, end_req, atr_bad} = 7'h40;
    {tx_active, tx_level, ans_en} = 3'h0;
    ans_delay = 16'h0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    start_req <= 1'b1;
    repeat (20) @(posedge clock);
    check("supply_unseated", supply_en, 1'b0);
    start_req <= 1'b0;
    ans_en <= 1'b1;
    ans_delay <= 16'd400 + 16'($random(seed) & 15);
    card_seated <= 1'b1;
    repeat (5) @(posedge clock);
    exp_q.push_back(2'b10);
    activate();
    for (int i = 0; i < 30000 && !session_ready; i++) @(posedge clock);
    check("ready", session_ready, 1'b1);
    tx_level <= 1'($random(seed));
    tx_active <= 1'b1;
    repeat (3) @(posedge clock);
    check("tx_drive", {io_oe_n, io_out}, {1'b0, tx_level});
    repeat (4) @(posedge clock);
    check("io_rx", io_rx, tx_level);
    tx_active <= 1'b0;
    repeat (3) @(posedge clock);
    check("tx_release", io_oe_n, 1'b1);
    ans_en <= 1'b0;
    exp_q.push_back(2'b01);
    atr_bad <= 1'b1;
    @(posedge clock);
    atr_bad <= 1'b0;
    hold_cnt = 0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 3000 && !card_rst; i++) @(posedge clock);
    check("warm_hold", 16'(hold_cnt), HOLD);
    check("warm_supply", supply_en, 1'b1);
    for (int i = 0; i < 52000 && !idle; i++) @(posedge clock);
    check("timeout_off", {idle, supply_en, card_clk, card_rst, io_oe_n}, 5'h10);
    for (int k = 0; k < 2; k++) begin
      card_seated <= 1'b0;
      // supply monitor drops with the supply, so the next activation waits for it again
      supply_ok <= 1'b0;
      repeat (8) @(posedge clock);
      card_seated <= 1'b1;
      repeat (5) @(posedge clock);
      activate();
      t0 = cycles;
      if (k == 0) end_req <= 1'b1;
      else card_pulled <= 1'b1;
      @(posedge clock);
      end_req <= 1'b0;
      repeat (10) @(posedge clock);
      check("deact_first", {card_rst, supply_en, io_oe_n}, 3'b011);
      for (int i = 0; i < 2000 && !idle; i++) @(posedge clock);
      check("deact_time", 16'(cycles - t0 < 800), 16'h1);
      check("deact_pins", {supply_en, card_clk, card_rst, io_oe_n, io_out}, 5'h0);
      card_pulled <= 1'b0;
    end
    check("queue_left", 16'(exp_q.size()), 16'h0);
    finish_test();
  end
endmodule // tb_card_session_sequencer
`default_nettype wire
